// >>> design/esic_ctrl.sv
`timescale 1ns/1ps
`include "esic_params.svh"
// Behaviour
// - Extra control register sits at SFR 0C0H, every bit writable singly.
// - Bits 7..0: priority3 enable3 flag3 type3 priority2 enable2 flag2 type2.
// - Priority bit one puts extra source on high level, zero on low.
// - Extra source requests taken only while its enable bit is set.
// - Type one: falling edge detects; type zero: low level detects.
// - Edge mode flag set by hardware on edge, cleared when serviced.
// - Vectors 03H..3BH step 8, polled external 0 first within a level.
// - Eight sources over exactly two priority levels.
// - Interrupt logic keeps clocking while processor idles.
// - Idle ends on any interrupt or reset.
// - Power-down ends on enabled edge-mode external 0..3 or reset.
module esic_ctrl
   import esic_pkg::*;
(
   // Clock and reset
   input  wire logic       MCLK,
   input  wire logic       RSTN,
   // SFR port
   input  wire logic       SFR_WR,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic [7:0] SFR_WDATA,
   output logic [7:0]      SFR_RDATA,
   // Standard source requests: ext0,t0,ext1,t1,serial,t2 and their enables/prios
   input  wire logic [5:0] SRC_REQ,
   input  wire logic [5:0] SRC_EN,
   input  wire logic [5:0] SRC_PRIO,
   input  wire logic [1:0] EXT01_EDGE,
   // Extra pins
   input  wire logic       EXTRA_IRQ_PIN2,
   input  wire logic       EXTRA_IRQ_PIN3,
   // Core handshake
   input  wire logic       GLOBAL_EN,
   input  wire logic       CORE_ACK,
   input  wire logic       CORE_RETI,
   output logic            IRQ_REQ,
   output logic [7:0]      IRQ_VECTOR,
   output logic [7:0]      SERVICE_ACK,
   // Power management
   input  wire logic       IDLE_REQUEST_BIT,
   input  wire logic       PDOWN_REQUEST,
   output logic            CPU_CLK_EN,
   output logic            OSC_EN
);
   // =====================================================
   // Pin synchronisers and edge detect
   logic pin2_s;
   logic pin3_s;
   logic pin2_d;
   logic pin3_d;
   esic_sync u_sync2 (.clk(MCLK), .rst_n(RSTN), .din(EXTRA_IRQ_PIN2), .dout(pin2_s));
   esic_sync u_sync3 (.clk(MCLK), .rst_n(RSTN), .din(EXTRA_IRQ_PIN3), .dout(pin3_s));
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         pin2_d <= 1'b1;
         pin3_d <= 1'b1;
      end else begin
         pin2_d <= pin2_s;
         pin3_d <= pin3_s;
      end
   end
   logic fall2;
   logic fall3;
   assign fall2 = pin2_d & ~pin2_s;
   assign fall3 = pin3_d & ~pin3_s;

   // =====================================================
   // Extra control register
   logic [7:0] xctrl;
   logic       wr_x;
   esic_req_t  sel;
   logic [2:0] act_lvl;
   logic       take;
   assign wr_x = SFR_WR && (SFR_ADDR == `ESIC_XCTRL_ADDR);
   assign take = IRQ_REQ && CORE_ACK;
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         xctrl <= `ESIC_XCTRL_RESET;
      end else begin
         if (wr_x) begin
            xctrl <= SFR_WDATA;
         end
         // Hardware set wins over software write and service clear
         if (take && IRQ_VECTOR == (`ESIC_VEC_BASE + 8'h30)
             && xctrl[`ESIC_BIT_TYPE2]) begin
            xctrl[`ESIC_BIT_FLAG2] <= 1'b0;
         end
         if (take && IRQ_VECTOR == (`ESIC_VEC_BASE + 8'h38)
             && xctrl[`ESIC_BIT_TYPE3]) begin
            xctrl[`ESIC_BIT_FLAG3] <= 1'b0;
         end
         if (xctrl[`ESIC_BIT_TYPE2] && fall2) begin
            xctrl[`ESIC_BIT_FLAG2] <= 1'b1;
         end
         if (xctrl[`ESIC_BIT_TYPE3] && fall3) begin
            xctrl[`ESIC_BIT_FLAG3] <= 1'b1;
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         SFR_RDATA <= 8'h00;
      end else begin
         SFR_RDATA <= (SFR_ADDR == `ESIC_XCTRL_ADDR) ? xctrl : 8'h00;
      end
   end

   // =====================================================
   // Request vector and arbitration
   logic [7:0] pend;
   logic [7:0] prio;
   always_comb begin
      pend[5:0] = SRC_REQ & SRC_EN;
      pend[6]   = xctrl[`ESIC_BIT_ENABLE2] &
                  (xctrl[`ESIC_BIT_TYPE2] ? xctrl[`ESIC_BIT_FLAG2] : ~pin2_s);
      pend[7]   = xctrl[`ESIC_BIT_ENABLE3] &
                  (xctrl[`ESIC_BIT_TYPE3] ? xctrl[`ESIC_BIT_FLAG3] : ~pin3_s);
      prio      = {xctrl[`ESIC_BIT_PRIO3], xctrl[`ESIC_BIT_PRIO2], SRC_PRIO};
   end
   // act_lvl[1]: high in service, act_lvl[0]: low in service
   esic_req_t next_sel;
   always_comb begin
      next_sel = '0;
      for (int i = `ESIC_NUM_SRC - 1; i >= 0; i--) begin
         if (pend[i] && !prio[i] && !next_sel.high) begin
            next_sel = '{valid: 1'b1, high: 1'b0, src: 3'(i)};
         end
      end
      for (int i = `ESIC_NUM_SRC - 1; i >= 0; i--) begin
         if (pend[i] && prio[i]) begin
            next_sel = '{valid: 1'b1, high: 1'b1, src: 3'(i)};
         end
      end
      if (!GLOBAL_EN || act_lvl[1] || (act_lvl[0] && !next_sel.high)) begin
         next_sel.valid = 1'b0;
      end
   end
   assign sel = next_sel;
   always_ff @(posedge MCLK) begin
      if (!RSTN || take) begin
         IRQ_REQ    <= 1'b0;
         IRQ_VECTOR <= 8'h00;
      end else begin
         IRQ_REQ    <= sel.valid;
         IRQ_VECTOR <= `ESIC_VEC_BASE + {2'h0, sel.src, 3'h0};
      end
   end
   logic [7:0] next_ack;
   always_comb begin
      next_ack = 8'h00;
      if (take) begin
         next_ack[IRQ_VECTOR[5:3]] = 1'b1;
      end
   end
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         SERVICE_ACK <= 8'h00;
      end else begin
         SERVICE_ACK <= next_ack;
      end
   end
   logic take_high;
   assign take_high = prio[IRQ_VECTOR[5:3]];
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         act_lvl <= 3'h0;
      end else if (take) begin
         act_lvl <= take_high ? {act_lvl[2], 1'b1, act_lvl[0]}
                              : {act_lvl[2:1], 1'b1};
      end else if (CORE_RETI) begin
         act_lvl <= act_lvl[1] ? {act_lvl[2], 1'b0, act_lvl[0]} : 3'h0;
      end
   end

   // =====================================================
   // Power management; this logic runs on MCLK throughout idle
   esic_pwr_t pwr;
   logic      wake_pd;
   assign wake_pd = (SRC_EN[0] && EXT01_EDGE[0] && SRC_REQ[0]) ||
                    (SRC_EN[2] && EXT01_EDGE[1] && SRC_REQ[2]) ||
                    (xctrl[`ESIC_BIT_ENABLE2] && xctrl[`ESIC_BIT_TYPE2] && fall2) ||
                    (xctrl[`ESIC_BIT_ENABLE3] && xctrl[`ESIC_BIT_TYPE3] && fall3);
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         pwr <= ESIC_RUN;
      end else begin
         unique case (pwr)
            ESIC_RUN: begin
               if (PDOWN_REQUEST) begin
                  pwr <= ESIC_PDOWN;
               end else if (IDLE_REQUEST_BIT) begin
                  pwr <= ESIC_IDLE;
               end
            end
            ESIC_IDLE: begin
               if (|(pend & {8{GLOBAL_EN}})) begin
                  pwr <= ESIC_RUN;
               end
            end
            ESIC_PDOWN: begin
               if (wake_pd) begin
                  pwr <= ESIC_RUN;
               end
            end
         endcase
      end
   end
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         CPU_CLK_EN <= 1'b1;
         OSC_EN     <= 1'b1;
      end else begin
         CPU_CLK_EN <= (pwr == ESIC_RUN);
         OSC_EN     <= (pwr != ESIC_PDOWN);
      end
   end

   // =====================================================
   // Checks
   sequence s_take_high;
      take && take_high;
   endsequence
   property p_flag2_set;
      @(posedge MCLK) disable iff (!RSTN)
      xctrl[`ESIC_BIT_TYPE2] && fall2 |=> xctrl[`ESIC_BIT_FLAG2];
   endproperty
   a_flag2_set: assert property (p_flag2_set) else $error("flag2 not set");
   property p_mask2;
      @(posedge MCLK) disable iff (!RSTN)
      !xctrl[`ESIC_BIT_ENABLE2] |-> !pend[6];
   endproperty
   a_mask2: assert property (p_mask2) else $error("masked source pending");
   property p_no_nest_high;
      @(posedge MCLK) disable iff (!RSTN)
      act_lvl[1] |=> !IRQ_REQ;
   endproperty
   a_no_nest_high: assert property (p_no_nest_high) else $error("nest at high");
   property p_high_mark;
      @(posedge MCLK) disable iff (!RSTN)
      s_take_high |=> act_lvl[1];
   endproperty
   a_high_mark: assert property (p_high_mark) else $error("high not marked");
   property p_vec_form;
      @(posedge MCLK) disable iff (!RSTN)
      IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3;
   endproperty
   a_vec_form: assert property (p_vec_form) else $error("bad vector");
   property p_idle_wake;
      @(posedge MCLK) disable iff (!RSTN)
      pwr == ESIC_IDLE && GLOBAL_EN && |pend |=> ##1 CPU_CLK_EN;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
   property p_pd_hold;
      @(posedge MCLK) disable iff (!RSTN)
      pwr == ESIC_PDOWN && !wake_pd |=> pwr == ESIC_PDOWN;
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("pdown left early");
   property p_sfr_write;
      @(posedge MCLK) disable iff (!RSTN)
      wr_x && !fall2 && !fall3 && !take |=> xctrl == $past(SFR_WDATA);
   endproperty
   a_sfr_write: assert property (p_sfr_write) else $error("write lost");
endmodule : esic_ctrl

// >>> design/esic_params.svh
`ifndef ESIC_PARAMS_SVH
`define ESIC_PARAMS_SVH
// =====================================================
// Register map and fields
`define ESIC_XCTRL_ADDR   8'hC0
`define ESIC_XCTRL_RESET  8'h00
`define ESIC_BIT_TYPE2    3'h0
`define ESIC_BIT_FLAG2    3'h1
`define ESIC_BIT_ENABLE2  3'h2
`define ESIC_BIT_PRIO2    3'h3
`define ESIC_BIT_TYPE3    3'h4
`define ESIC_BIT_FLAG3    3'h5
`define ESIC_BIT_ENABLE3  3'h6
`define ESIC_BIT_PRIO3    3'h7
// =====================================================
// Vectors
`define ESIC_VEC_BASE     8'h03
`define ESIC_VEC_STEP     8'h08
`define ESIC_NUM_SRC      8
`endif

// >>> design/esic_pkg.sv
package esic_pkg;
   // =====================================================
   // Types
   typedef struct packed {
      logic       valid;
      logic       high;
      logic [2:0] src;
   } esic_req_t;
   typedef enum logic [1:0] {ESIC_RUN, ESIC_IDLE, ESIC_PDOWN} esic_pwr_t;
endpackage : esic_pkg

// >>> design/esic_sync.sv
`timescale 1ns/1ps
// =====================================================
// Three-stage pin synchroniser; level changes once stages 2 and 3 agree
module esic_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] sr;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sr   <= 3'h7;
         dout <= 1'b1;
      end else begin
         sr <= {sr[1:0], din};
         if (sr[1] == sr[2]) begin
            dout <= sr[2];
         end
      end
   end
endmodule : esic_sync

// >>> testbench/esic_core_model.sv
`timescale 1ns/1ps
// ====================
// Core side: takes one vector at a time, ends service after reti_delay cycles
module esic_core_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Controller side
   input  wire logic       irq_req,
   input  wire logic [7:0] irq_vector,
   output logic            ack = 1'b0,
   output logic            reti = 1'b0
);
   logic [7:0] vec_q[$];
   int         wait_cnt = 0;
   int         reti_delay = 6;
   always @(posedge clk) begin
      ack  <= 1'b0;
      reti <= 1'b0;
      if (!rst_n) begin
         wait_cnt <= 0;
      end else if (wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
         reti     <= (wait_cnt == 1);
      end else if (irq_req && !ack) begin
         ack      <= 1'b1;
         wait_cnt <= reti_delay;
         vec_q.push_back(irq_vector);
      end
   end
endmodule : esic_core_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import esic_pkg::*;
   // ====================
   // Signals
   logic       mclk = 0, rstn = 0, wr = 0, pin2 = 1, pin3 = 1, glob = 0, idle = 0, pdn = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, vec, sack, d, rd;
   logic [5:0] req = 6'h00, en = 6'h00, prio = 6'h00;
   logic [1:0] edge01 = 2'h0;
   logic       irq, ack, reti, cpu_en, osc_en;
   int         n_mismatch = 0, compares = 0, seed = 32'h768ae7aa, i;
   logic [7:0] exp_q[$];
   logic [7:0] sack_q[$];
   esic_ctrl esic_ctrl_i (.MCLK(mclk), .RSTN(rstn), .SFR_WR(wr), .SFR_ADDR(addr),
      .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SRC_REQ(req), .SRC_EN(en), .SRC_PRIO(prio),
      .EXT01_EDGE(edge01), .EXTRA_IRQ_PIN2(pin2), .EXTRA_IRQ_PIN3(pin3), .GLOBAL_EN(glob),
      .CORE_ACK(ack), .CORE_RETI(reti), .IRQ_REQ(irq), .IRQ_VECTOR(vec), .SERVICE_ACK(sack),
      .IDLE_REQUEST_BIT(idle), .PDOWN_REQUEST(pdn), .CPU_CLK_EN(cpu_en), .OSC_EN(osc_en));
   esic_core_model esic_core_model_i (.clk(mclk), .rst_n(rstn), .irq_req(irq),
      .irq_vector(vec), .ack(ack), .reti(reti));
   initial forever #50 mclk = ~mclk;
   // Serviced sources 0..5 and 7 drop their request
   always @(posedge mclk) begin
      if (sack != 8'h00) begin
         sack_q.push_back(sack);
         req <= req & ~sack[5:0];
         if (sack[7]) pin3 <= 1'b1;
      end
   end
   // ====================
   // Tasks
   task automatic tick(int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic cmp(string name, logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask : cmp
   task automatic cmp_vecs();
      int w;
      for (w = 0; w < 400 && esic_core_model_i.vec_q.size() < exp_q.size(); w++) tick(1);
      if (w == 400) begin
         n_mismatch++;
         summarize();
      end
      tick(12);
      cmp("vector_count", 8'(exp_q.size()), 8'(esic_core_model_i.vec_q.size()));
      foreach (exp_q[k]) cmp("vector", exp_q[k], esic_core_model_i.vec_q[k]);
      cmp("service_count", 8'(exp_q.size()), 8'(sack_q.size()));
      foreach (exp_q[k]) cmp("service_ack", 8'h01 << exp_q[k][5:3], sack_q[k]);
      exp_q.delete();
      esic_core_model_i.vec_q.delete();
      sack_q.delete();
   endtask : cmp_vecs
   task automatic sfr_write(logic [7:0] a, logic [7:0] v);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : sfr_write
   task automatic sfr_read(logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      @(posedge mclk);
      @(posedge mclk);
      v = rdata;
   endtask : sfr_read
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   // ====================
   // Sequence
   initial begin
      tick(2);
      rstn <= 1'b1;
      sfr_read(8'hC0, d);
      cmp("xctrl_reset", 8'h00, d);
      cmp("clk_en_reset", 8'h03, {6'h0, cpu_en, osc_en});
      for (int k = 0; k < 12; k++) begin
         d = (k < 8) ? 8'h01 << k : 8'($random(seed));
         sfr_write(8'hC0, d);
         sfr_write(8'hC1, ~d);
         sfr_read(8'hC0, rd);
         cmp("xctrl", d, rd);
         sfr_read(8'hC1, rd);
         cmp("unmapped", 8'h00, rd);
      end
      $display("test registers done");
      sfr_write(8'hC0, 8'h00);
      @(posedge mclk);
      glob <= 1'b1;
      en   <= 6'h3F;
      req  <= 6'h3F;
      for (int k = 0; k < 6; k++) exp_q.push_back(8'h03 + 8'h08 * k);
      cmp_vecs();
      $display("test polling order done");
      sfr_write(8'hC0, 8'h01);
      pin2 <= 1'b0;
      tick(10);
      cmp("masked_irq", 8'h00, {7'h0, irq});
      sfr_read(8'hC0, d);
      cmp("edge_flag", 8'h03, d);
      pin2 <= 1'b1;
      sfr_write(8'hC0, 8'hC5);
      tick(8);
      pin2 <= 1'b0;
      pin3 <= 1'b0;
      exp_q = '{8'h3B, 8'h33};
      cmp_vecs();
      sfr_read(8'hC0, d);
      cmp("flag_cleared", 8'hC5, d);
      pin2 <= 1'b1;
      $display("test extra pins done");
      edge01 <= 2'h3;
      for (int p = 0; p < 2; p++) begin
         @(posedge mclk);
         idle <= (p == 0);
         pdn  <= (p == 1);
         @(posedge mclk);
         idle <= 1'b0;
         pdn  <= 1'b0;
         tick(3);
         cmp("stopped", (p == 0) ? 8'h01 : 8'h00, {6'h0, cpu_en, osc_en});
         req <= 6'h01;
         exp_q.push_back(8'h03);
         for (i = 0; i < 50 && !(cpu_en === 1'b1); i++) tick(1);
         if (i == 50) begin
            n_mismatch++;
            summarize();
         end
         cmp("woken", 8'h03, {6'h0, cpu_en, osc_en});
         cmp_vecs();
      end
      $display("test power done");
      summarize();
   end
   initial begin
      tick(20000);
      n_mismatch++;
      summarize();
   end
endmodule : tb_top
